// file: rtl/dse_exec.sv
// Execution unit for the decrement-and-skip instructions
`timescale 1ns/1ps
module dse_exec (
    // Clock, reset, enable
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        en_i,
    // Instruction from the prefetch stage
    input  wire dse_pkg::dse_instr_s         instr_i,
    input  wire logic                        instr_valid_i,
    input  wire logic                        next_two_word_i,
    output logic                             instr_ready_o,
    // Addressing context
    input  wire logic [dse_pkg::BANK_W-1:0]  bank_select_register_i,
    input  wire logic                        ext_set_en_i,
    input  wire logic [dse_pkg::ADDR_W-1:0]  index_base_i,
    // Data memory
    output dse_pkg::dse_dmem_s               dmem_o,
    input  wire logic [dse_pkg::DATA_W-1:0]  dmem_rdata_i,
    // Working register
    output logic                             w_we_o,
    output logic [dse_pkg::DATA_W-1:0]       w_wdata_o,
    // Pipeline control
    output logic                             skip_o,
    output logic                             discard_o
);
    import dse_pkg::*;

    dse_state_s              st_q;
    dse_state_s              st_d;
    logic                    accept;
    logic                    match;
    logic                    skip_cond;
    logic [ADDR_W-1:0]       ea;

    assign instr_ready_o = (st_q.phase == PH_Q1) && (st_q.fsm == DSE_EXEC);
    assign accept        = instr_ready_o && instr_valid_i;
    assign match         = (instr_i.opcode == OPC_SKIP_ZERO) ||
                           (instr_i.opcode == OPC_SKIP_NZ);
    // Skip test sits on the stored result so it matches what was written
    assign skip_cond     = st_q.nz_kind ? (st_q.result != ZERO_BYTE)
                                        : (st_q.result == ZERO_BYTE);

    // Operand address; the indexed case wins over the plain access bank
    always_comb begin
        if (instr_i.acc) begin
            ea = {bank_select_register_i, instr_i.file};
        end else if (ext_set_en_i && (instr_i.file <= ACC_LOW_MAX)) begin
            ea = index_base_i + {ACC_LOW_BANK, instr_i.file};
        end else if (instr_i.file <= ACC_LOW_MAX) begin
            ea = {ACC_LOW_BANK, instr_i.file};
        end else begin
            ea = {ACC_HIGH_BANK, instr_i.file};
        end
    end

    always_comb begin
        st_d        = st_q;
        st_d.phase  = st_q.phase + PH_STEP;
        st_d.mem_re = 1'b0;
        st_d.mem_we = 1'b0;
        st_d.w_we   = 1'b0;
        st_d.skip   = 1'b0;
        case (st_q.phase)
            PH_Q1: begin
                // Decode; other opcodes are left to other units
                st_d.act     = accept && match;
                st_d.mem_re  = accept && match;
                // Operand context is kept until the next taken instruction
                if (accept && match) begin
                    st_d.nz_kind = (instr_i.opcode == OPC_SKIP_NZ);
                    st_d.dst     = instr_i.dst;
                    st_d.addr    = ea;
                end
            end
            PH_Q2: begin
                if (st_q.act) begin
                    st_d.data = dmem_rdata_i;
                end
            end
            PH_Q3: begin
                st_d.result = st_q.data - DEC_STEP;
                st_d.mem_we = st_q.act && st_q.dst;
                st_d.w_we   = st_q.act && !st_q.dst;
            end
            PH_Q4: begin
                st_d.act = 1'b0;
                case (st_q.fsm)
                    DSE_EXEC: begin
                        if (st_q.act && skip_cond) begin
                            st_d.fsm      = DSE_NOP1;
                            st_d.two_word = next_two_word_i;
                            st_d.skip     = 1'b1;
                        end else begin
                            st_d.fsm      = DSE_EXEC;
                            st_d.two_word = 1'b0;
                        end
                    end
                    DSE_NOP1: begin
                        // Second word of a skipped two-word instruction is eaten too
                        st_d.fsm = st_q.two_word ? DSE_NOP2 : DSE_EXEC;
                    end
                    DSE_NOP2: begin
                        st_d.fsm      = DSE_EXEC;
                        st_d.two_word = 1'b0;
                    end
                    default: begin
                        st_d.fsm = DSE_EXEC;
                    end
                endcase
                st_d.discard = (st_d.fsm != DSE_EXEC);
            end
            default: begin
                st_d.phase = PH_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= STATE_RST;
        end else if (en_i) begin
            st_q <= st_d;
        end
    end

    // No status flags are touched here; only the destination is written
    // One driver for the whole carrier keeps strict tools content
    assign dmem_o       = '{
        re:    st_q.mem_re,
        we:    st_q.mem_we,
        addr:  st_q.addr,
        wdata: st_q.result
    };
    assign w_we_o       = st_q.w_we;
    assign w_wdata_o    = st_q.result;
    assign skip_o       = st_q.skip;
    assign discard_o    = st_q.discard;

    // Checks, stepping only on enabled edges
    default clocking dse_cb @(posedge clk_i iff en_i);
    endclocking
    default disable iff (rst_i);

    a_file_writeback: assert property (
        (st_q.phase == PH_Q3 && st_q.act && st_q.dst)
            |=> dmem_o.we && !w_we_o && dmem_o.wdata == $past(st_q.data) - DEC_STEP)
        else $error("file destination not written with decremented value");

    a_w_writeback: assert property (
        (st_q.phase == PH_Q3 && st_q.act && !st_q.dst)
            |=> w_we_o && !dmem_o.we && w_wdata_o == $past(st_q.data) - DEC_STEP)
        else $error("working register destination not written");

    a_skip_on_zero: assert property (
        (st_q.phase == PH_Q4 && st_q.act && !st_q.nz_kind && st_q.fsm == DSE_EXEC)
            |=> skip_o == ($past(st_q.result) == ZERO_BYTE))
        else $error("skip-if-zero decision wrong");

    a_skip_on_nonzero: assert property (
        (st_q.phase == PH_Q4 && st_q.act && st_q.nz_kind && st_q.fsm == DSE_EXEC)
            |=> skip_o == ($past(st_q.result) != ZERO_BYTE))
        else $error("skip-if-nonzero decision wrong");

    a_one_nop_cycle: assert property (
        (skip_o && !st_q.two_word) |-> discard_o [*4] ##1 !discard_o && instr_ready_o)
        else $error("single skip did not flush exactly one cycle");

    a_two_nop_cycles: assert property (
        (skip_o && st_q.two_word) |-> discard_o [*8] ##1 !discard_o && instr_ready_o)
        else $error("two-word skip did not flush exactly two cycles");

    a_access_bank_addr: assert property (
        (accept && match && !instr_i.acc && !(ext_set_en_i && instr_i.file <= ACC_LOW_MAX))
            |=> dmem_o.re && dmem_o.addr[7:0] == $past(instr_i.file)
                && dmem_o.addr[11:8] == ($past(instr_i.file) <= ACC_LOW_MAX
                                         ? ACC_LOW_BANK : ACC_HIGH_BANK))
        else $error("access bank address wrong");

    a_banked_addr: assert property (
        (accept && match && instr_i.acc)
            |=> dmem_o.addr == {$past(bank_select_register_i), $past(instr_i.file)})
        else $error("banked address wrong");

    a_indexed_addr: assert property (
        (accept && match && !instr_i.acc && ext_set_en_i && instr_i.file <= ACC_LOW_MAX)
            |=> dmem_o.addr == $past(index_base_i) + {ACC_LOW_BANK, $past(instr_i.file)})
        else $error("indexed literal offset address wrong");

    a_foreign_opcode: assert property (
        (accept && !match) |=> !dmem_o.re ##1 1'b1 ##1 !dmem_o.we && !w_we_o)
        else $error("foreign opcode was executed");

    a_quarter_order: assert property (
        dmem_o.re |-> st_q.phase == PH_Q2 ##2 (dmem_o.we || w_we_o) && st_q.phase == PH_Q4)
        else $error("quarter phase order broken");

    a_data_capture: assert property (
        (st_q.phase == PH_Q2 && st_q.act) |=> st_q.data == $past(dmem_rdata_i))
        else $error("operand not captured at the end of the read quarter");

    a_idle_no_write: assert property (
        (st_q.phase == PH_Q3 && !st_q.act) |=> !dmem_o.we && !w_we_o)
        else $error("destination written without a taken instruction");

    a_flush_quiet: assert property (
        discard_o |-> !dmem_o.re && !dmem_o.we && !w_we_o)
        else $error("memory or working register touched during a flush");

    a_skip_pulse_q1: assert property (
        skip_o |-> st_q.phase == PH_Q1 && discard_o)
        else $error("skip pulse not aligned with the start of the flush");

    a_addr_hold: assert property (
        !(accept && match) |=> $stable(dmem_o.addr))
        else $error("operand address moved without a taken instruction");

    // Frozen edges are invisible to the default clock, so this one watches the raw edge
    a_enable_freeze: assert property (
        @(posedge clk_i) disable iff (rst_i) !en_i |=> $stable(st_q))
        else $error("state moved while the clock enable was low");

    c_skip_zero: cover property (skip_o && !st_q.nz_kind);
    c_skip_nonzero: cover property (skip_o && st_q.nz_kind);
    c_two_word_skip: cover property (skip_o && st_q.two_word);
    c_no_skip_file: cover property (dmem_o.we && st_q.fsm == DSE_EXEC);
    c_indexed_read: cover property (accept && match && !instr_i.acc && ext_set_en_i);

endmodule : dse_exec

// file: rtl/dse_pkg.sv
// Constants, types and carriers for the decrement-and-skip execution unit
//
// Overview of operation
// - Subtract one from file; destination bit 0 writes W, 1 writes file back.
// - Skip-if-zero form skips the next instruction when the result is zero.
// - Skip-if-nonzero form skips the next instruction when the result is not zero.
// - A skip discards the prefetched word and runs one no-operation cycle instead.
// - Skipping a two-word instruction runs two no-operation cycles, three in total.
// - Access bit 0 addresses the operand through the fixed access bank.
// - Access bit 1 forms the address from bank select register and file field.
// - Access bit 0, extended set on and file at most 95: indexed literal offset.
package dse_pkg;

    localparam int          DATA_W        = 8;
    localparam int          BANK_W        = 4;
    localparam int          ADDR_W        = 12;

    // Opcode fields
    localparam logic [5:0]  OPC_SKIP_ZERO = 6'h0b;
    localparam logic [5:0]  OPC_SKIP_NZ   = 6'h13;

    // Addressing
    localparam logic [7:0]  ACC_LOW_MAX   = 8'h5f;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
    localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;

    // Quarter phases of one instruction cycle
    localparam logic [1:0]  PH_Q1         = 2'h0;
    localparam logic [1:0]  PH_Q2         = 2'h1;
    localparam logic [1:0]  PH_Q3         = 2'h2;
    localparam logic [1:0]  PH_Q4         = 2'h3;
    localparam logic [1:0]  PH_STEP       = 2'h1;
    localparam logic [7:0]  DEC_STEP      = 8'h01;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;

    typedef enum logic [2:0] {
        DSE_EXEC = 3'b001,
        DSE_NOP1 = 3'b010,
        DSE_NOP2 = 3'b100
    } dse_fsm_e;

    // One instruction word
    typedef struct packed {
        logic [5:0]        opcode;
        logic              dst;
        logic              acc;
        logic [7:0]        file;
    } dse_instr_s;

    // Data memory request
    typedef struct packed {
        logic              re;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dse_dmem_s;

    // Whole state of the unit
    typedef struct packed {
        logic [1:0]        phase;
        dse_fsm_e          fsm;
        logic              act;
        logic              nz_kind;
        logic              dst;
        logic              two_word;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] result;
        logic              mem_re;
        logic              mem_we;
        logic              w_we;
        logic              skip;
        logic              discard;
    } dse_state_s;

    localparam dse_state_s STATE_RST = '{
        phase: PH_Q1, fsm: DSE_EXEC, act: 1'b0, nz_kind: 1'b0, dst: 1'b0,
        two_word: 1'b0, addr: '0, data: '0, result: '0, mem_re: 1'b0,
        mem_we: 1'b0, w_we: 1'b0, skip: 1'b0, discard: 1'b0
    };

endpackage : dse_pkg

// file: sim/testbench.sv
// Self-checking bench for the decrement-and-skip execution unit
`timescale 1ns/1ps
module testbench;
    import dse_pkg::*;
    logic              clk_i, rst_i, en_i, instr_valid_i, next_two_word_i, ext_set_en_i;
    dse_instr_s        instr_i;
    logic [BANK_W-1:0] bank_select_register_i;
    logic [ADDR_W-1:0] index_base_i;
    logic [DATA_W-1:0] dmem_rdata_i, w_wdata_o;
    logic              instr_ready_o, w_we_o, skip_o, discard_o;
    dse_dmem_s         dmem_o;
    int                bad_count, n_compared;
    int                cycles = 0;

    dse_exec dse_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
        .instr_ready_o(instr_ready_o), .bank_select_register_i(bank_select_register_i),
        .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i), .dmem_o(dmem_o),
        .dmem_rdata_i(dmem_rdata_i), .w_we_o(w_we_o), .w_wdata_o(w_wdata_o),
        .skip_o(skip_o), .discard_o(discard_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    // Runs one instruction from a Q1 falling edge and returns at the next ready Q1
    task automatic run_op(input logic [5:0] opc, input logic dst, input logic acc,
                          input logic [7:0] file, input logic [7:0] rd, input logic two,
                          input logic [11:0] ea);
        logic [7:0] res;
        logic       skp;
        res = rd - DEC_STEP;
        skp = (opc == OPC_SKIP_ZERO) ? (res == ZERO_BYTE) : (res != ZERO_BYTE);
        instr_i = '{opcode: opc, dst: dst, acc: acc, file: file};
        instr_valid_i = 1'b1;
        next_two_word_i = two;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        dmem_rdata_i = rd;
        chk_bit("read strobe", 1'b1, dmem_o.re);
        chk_val("address", ea, dmem_o.addr);
        repeat (2) @(negedge clk_i);
        // Read data no longer valid once sampled
        dmem_rdata_i = ~rd;
        chk_bit("file write", dst, dmem_o.we);
        chk_bit("w write", ~dst, w_we_o);
        chk_val("file data", {4'h0, res}, {4'h0, dmem_o.wdata});
        chk_val("w data", {4'h0, res}, {4'h0, w_wdata_o});
        @(negedge clk_i);
        chk_bit("skip", skp, skip_o);
        chk_bit("ready", ~skp, instr_ready_o);
        if (skp) begin
            repeat (two ? 8 : 4) begin
                chk_bit("flush", 1'b1, discard_o);
                chk_bit("no write", 1'b0, dmem_o.we | w_we_o);
                @(negedge clk_i);
            end
            chk_bit("ready after flush", 1'b1, instr_ready_o);
        end
        chk_bit("flush end", 1'b0, discard_o);
    endtask : run_op

    task automatic sc_zero_skip;
        run_op(OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h3c, 8'h01, 1'b0, 12'h53c);
    endtask : sc_zero_skip

    task automatic sc_zero_stay;
        run_op(OPC_SKIP_ZERO, 1'b0, 1'b0, 8'h5f, 8'h00, 1'b0, 12'h05f);
        run_op(OPC_SKIP_ZERO, 1'b1, 1'b0, 8'hff, 8'h02, 1'b1, 12'hfff);
    endtask : sc_zero_stay

    task automatic sc_nz_two_word;
        run_op(OPC_SKIP_NZ, 1'b1, 1'b0, 8'h60, 8'h00, 1'b1, 12'hf60);
        run_op(OPC_SKIP_NZ, 1'b0, 1'b1, 8'h00, 8'h01, 1'b1, 12'h500);
    endtask : sc_nz_two_word

    task automatic sc_indexed;
        ext_set_en_i = 1'b1;
        run_op(OPC_SKIP_NZ, 1'b0, 1'b0, 8'h5f, 8'h01, 1'b0, 12'h182);
        run_op(OPC_SKIP_ZERO, 1'b0, 1'b0, 8'h60, 8'h05, 1'b0, 12'hf60);
        run_op(OPC_SKIP_NZ, 1'b1, 1'b1, 8'h10, 8'h05, 1'b0, 12'h510);
        ext_set_en_i = 1'b0;
    endtask : sc_indexed

    task automatic sc_other_opcode;
        instr_i = '{opcode: 6'h01, dst: 1'b1, acc: 1'b1, file: 8'h20};
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk_bit("foreign read", 1'b0, dmem_o.re);
        repeat (2) @(negedge clk_i);
        chk_bit("foreign write", 1'b0, dmem_o.we | w_we_o);
        @(negedge clk_i);
        chk_bit("foreign skip", 1'b0, skip_o);
        chk_bit("foreign ready", 1'b1, instr_ready_o);
    endtask : sc_other_opcode

    task automatic sc_enable_freeze;
        instr_i = '{opcode: OPC_SKIP_NZ, dst: 1'b1, acc: 1'b1, file: 8'h21};
        instr_valid_i = 1'b1;
        next_two_word_i = 1'b0;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        dmem_rdata_i = 8'h07;
        en_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk_bit("frozen read", 1'b1, dmem_o.re);
        chk_val("frozen address", 12'h521, dmem_o.addr);
        chk_bit("frozen ready", 1'b0, instr_ready_o);
        en_i = 1'b1;
        repeat (2) @(negedge clk_i);
        dmem_rdata_i = 8'h00;
        chk_bit("resumed write", 1'b1, dmem_o.we);
        chk_val("resumed data", 12'h006, {4'h0, dmem_o.wdata});
        @(negedge clk_i);
        chk_bit("resumed skip", 1'b1, skip_o);
        repeat (4) @(negedge clk_i);
        chk_bit("resumed ready", 1'b1, instr_ready_o);
        chk_bit("resumed flush end", 1'b0, discard_o);
    endtask : sc_enable_freeze

    task automatic sc_reset_mid;
        instr_i = '{opcode: OPC_SKIP_ZERO, dst: 1'b1, acc: 1'b1, file: 8'h44};
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        rst_i = 1'b1;
        #1;
        chk_bit("reset read", 1'b0, dmem_o.re);
        chk_bit("reset ready", 1'b1, instr_ready_o);
        @(negedge clk_i);
        rst_i = 1'b0;
        run_op(OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h44, 8'h01, 1'b0, 12'h544);
    endtask : sc_reset_mid

    initial begin
        rst_i = 1'b1;
        en_i = 1'b1;
        instr_valid_i = 1'b0;
        next_two_word_i = 1'b0;
        ext_set_en_i = 1'b0;
        instr_i = '0;
        bank_select_register_i = 4'h5;
        index_base_i = 12'h123;
        dmem_rdata_i = 8'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        sc_zero_skip();
        sc_zero_stay();
        sc_nz_two_word();
        sc_indexed();
        sc_other_opcode();
        sc_enable_freeze();
        sc_reset_mid();
        tally_and_finish();
    end

    // Whole run needs under a hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles >= 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end
endmodule : testbench
